// File: icto_defines.svh
`ifndef ICTO_DEFINES_SVH
`define ICTO_DEFINES_SVH

// ==========================================================
// Register map
`define ICTO_A_CTRL      8'h00
`define ICTO_A_IRQ_ST    8'h04
`define ICTO_A_IRQ_MASK  8'h08
`define ICTO_A_STATE     8'h0c
`define ICTO_OUT_SEL     3'b010
`define ICTO_CH_SEL      1'b1
`define ICTO_F_P1        3'h0
`define ICTO_F_S1        3'h1
`define ICTO_F_P2        3'h2
`define ICTO_F_S2        3'h3
`define ICTO_F_TC        3'h4
`define ICTO_F_PV        3'h5
`define ICTO_F_CODE      1'b0
`define ICTO_F_PER       1'b1

// ==========================================================
// Field positions
`define ICTO_IRQ_REFUSED 4
`define ICTO_ERR_MSB     13

// ==========================================================
// Ranges and reset values
`define ICTO_VAL_MIN     16'shf831
`define ICTO_VAL_MAX     16'sh270f
`define ICTO_TC_MAX      16'h270f
`define ICTO_P1_RST      16'sh0000
`define ICTO_P2_RST      16'sh03e8
`define ICTO_S_RST       16'sh0000
`define ICTO_TC_RST      16'h0000
`define ICTO_CODE_MAX    8'h90
`define ICTO_CODE_O1     8'h2f
`define ICTO_CODE_O2     8'h4f
`define ICTO_CODE_O3_4CH 8'h6f
`define ICTO_CODE_O4_4CH 8'h8f
`define ICTO_CODE_O3_2CH 8'h20
`define ICTO_CODE_O4_2CH 8'h40
`define ICTO_CODE_ERR    8'h01
`define ICTO_CODE_GRP    8'h20
`define ICTO_SUB_PROP    5'h0f
`define ICTO_PER_MAX     7'h63
`define ICTO_PER_RST     7'h02
`define ICTO_PCT_FULL    10'h3e8

// ==========================================================
// Timing
`define ICTO_CLK_NS      4
`define ICTO_TICK_NS     1000000
`define ICTO_MS_PER_S    17'h003e8
`define ICTO_PER_ZERO_MS 17'h001f4
`define ICTO_MS_PER_TC   20'h00064
`define ICTO_DEC_DIV     17'sh0000a
`define ICTO_FRAC        24
`define ICTO_ONE         45'h000_0100_0000

`endif

// File: icto_pkg.sv
`default_nettype none

package icto_pkg;
    `include "icto_defines.svh"

    typedef logic signed [15:0] icto_val_t;
    typedef logic        [9:0]  icto_pct_t;

    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_RUN  = 1'b1
    } icto_ph_t;

    typedef struct packed {
        icto_val_t   p1;
        icto_val_t   s1;
        icto_val_t   p2;
        icto_val_t   s2;
        logic [15:0] tc;
        logic [17:0] recip;
        logic signed [39:0] flt;
    } icto_ch_t;

    typedef struct packed {
        logic [7:0]  code;
        logic [6:0]  per;
        logic [16:0] cnt;
        icto_pct_t   mvl;
    } icto_out_t;

    typedef struct packed {
        logic              lin;
        logic [4:0]        irq_st;
        logic [4:0]        irq_mask;
        icto_ch_t  [3:0]   ch;
        icto_out_t [3:0]   op;
        logic [17:0]       tick_cnt;
        icto_ph_t          ph;
        logic [1:0]        chi;
        logic [31:0]       rdata;
        logic [3:0]        on;
        icto_pct_t [3:0]   lvl;
    } icto_st_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } icto_bus_t;
endpackage

`default_nettype wire

// File: icto_core.sv
// Operation
// RULE1 - Equal shifts add one offset everywhere
// RULE2 - Unequal shifts give line through two points
// RULE3 - Correction points clamped, defaults 0 and 1000
// RULE4 - Shifts clamped, default 0, decimal 0 as 1
// RULE5 - Programmable filter time constant 0.0-999.9 s
// RULE6 - First-order settling, zero constant passes through
// RULE7 - Each output picks source by code 0-144
// RULE8 - Four-channel defaults 47, 79, 111, 143
// RULE9 - Two-channel outputs 3,4 default 32, 64
// RULE10 - Error source on when status bits 0-13
// RULE11 - Linear outputs: digital source gives 100/0%
// RULE12 - Assignment codes writable only while stopped
// RULE13 - Output on for manipulated value fraction of period
// RULE14 - Per-output period 0-99 s, default 2
// RULE15 - Period setting 0 means 0.5 s
// RULE16 - Period writable only while stopped
// RULE17 - Period only for 2-PID, not linear 1-2
// RULE18 - Relay heaters: period at least 20 s (not enforced; any period 0-99 is accepted)
// RULE19 - Extrapolate line; equal points use shift 1
`timescale 1ns/1ps
`default_nettype none
`include "icto_defines.svh"

module icto_core
    import icto_pkg::*;
#(
    parameter int unsigned TICK_CYC = `ICTO_TICK_NS / `ICTO_CLK_NS
) (
    input  wire logic            mclk_in,        // 250 MHz clock
    input  wire logic            rst_b_in,       // Sync reset, low
    input  wire logic            four_ch_in,     // Variant strap
    input  wire icto_bus_t       bus_in,         // Register port
    output logic [31:0]          rdata_out,      // Read data
    output logic                 irq_out,        // Interrupt level
    input  wire logic            run_in,         // Control running
    input  wire icto_val_t [3:0] meas_in,        // Measured values
    input  wire logic [3:0][1:0] dp_in,          // Sensor decimals
    input  wire icto_pct_t [3:0] mv_in,          // Manipulated value
    input  wire logic [3:0]      pid_in,         // 2-PID, else on/off
    input  wire logic [3:0]      alarm_in,       // Digital sources
    input  wire logic [15:0]     dev_status_in,  // Device status
    output logic [3:0]           out_on_out,     // Pulse outputs
    output icto_pct_t [3:0]      out_lin_out,    // Linear levels
    output icto_val_t [3:0]      pv_out          // Filtered values
);

    // ==========================================================
    // Helpers
    function automatic icto_val_t clamp_val(input logic [31:0] w);
        logic signed [31:0] v;
        v = w;
        if (v < 32'(`ICTO_VAL_MIN)) begin
            clamp_val = `ICTO_VAL_MIN;
        end else if (v > 32'(`ICTO_VAL_MAX)) begin
            clamp_val = `ICTO_VAL_MAX;
        end else begin
            clamp_val = v[15:0];
        end
    endfunction

    // Decimal setting 0 stores shifts in tenths
    function automatic logic signed [16:0] shift_eff(input icto_val_t s,
                                                     input logic [1:0] dp);
        logic signed [16:0] t;
        t = 17'(s);
        if (dp == 2'h0) begin
            shift_eff = t / `ICTO_DEC_DIV; // RULE4
        end else begin
            shift_eff = t;
        end
    endfunction

    function automatic icto_val_t correct(input icto_val_t x,
                                          input icto_ch_t c,
                                          input logic [1:0] dp);
        logic signed [16:0] a;
        logic signed [16:0] b;
        logic signed [16:0] dx;
        logic signed [16:0] dp12;
        logic signed [35:0] prod;
        logic signed [35:0] sum;
        a    = shift_eff(c.s1, dp);
        b    = shift_eff(c.s2, dp);
        dx   = 17'(x) - 17'(c.p1);
        dp12 = 17'(c.p2) - 17'(c.p1);
        if (c.s1 == c.s2 || dp12 == 17'sh0) begin
            sum = 36'(x) + 36'(a); // RULE1 RULE19
        end else begin
            // Same line reaches past both points
            prod = 36'(b - a) * 36'(dx); // RULE2 RULE19
            sum  = 36'(x) + 36'(a) + prod / 36'(dp12);
        end
        if (sum < 36'(-32768)) begin
            correct = 16'sh8000;
        end else if (sum > 36'(32767)) begin
            correct = 16'sh7fff;
        end else begin
            correct = sum[15:0];
        end
    endfunction

    function automatic logic [16:0] period_ms(input logic [6:0] per);
        if (per == 7'h0) begin
            period_ms = `ICTO_PER_ZERO_MS; // RULE15
        end else begin
            period_ms = 17'(per * `ICTO_MS_PER_S); // RULE14
        end
    endfunction

    icto_st_t st_r;
    icto_st_t st_nxt;

    // ==========================================================
    // Next state
    always_comb begin
        logic              tick;
        logic [1:0]        sel;
        logic [2:0]        fld;
        logic [4:0]        ev;
        logic [19:0]       den;
        icto_val_t         xc;
        logic signed [16:0] err;
        logic signed [36:0] dlt;
        logic [16:0]       pms;
        logic [1:0]        src;
        logic              prop;
        logic              dig;
        logic              on;
        icto_pct_t         mv;
        tick  = 1'b0;
        sel   = 2'h0;
        fld   = 3'h0;
        ev    = 5'h0;
        den   = 20'h0;
        xc    = '0;
        err   = '0;
        dlt   = '0;
        pms   = '0;
        src   = 2'h0;
        prop  = 1'b0;
        dig   = 1'b0;
        on    = 1'b0;
        mv    = '0;
        st_nxt = st_r;
        st_nxt.rdata = 32'h0;

        tick = (st_r.tick_cnt == 18'(TICK_CYC - 1));
        st_nxt.tick_cnt = tick ? 18'h0 : st_r.tick_cnt + 18'h1;

        // Register writes
        if (bus_in.wr) begin
            if (bus_in.addr == `ICTO_A_CTRL) begin
                st_nxt.lin = bus_in.wdata[0];
            end else if (bus_in.addr == `ICTO_A_IRQ_ST) begin
                st_nxt.irq_st = st_r.irq_st & ~bus_in.wdata[4:0];
            end else if (bus_in.addr == `ICTO_A_IRQ_MASK) begin
                st_nxt.irq_mask = bus_in.wdata[4:0];
            end else if (bus_in.addr[7] == `ICTO_CH_SEL) begin
                sel = bus_in.addr[6:5];
                fld = bus_in.addr[4:2];
                case (fld)
                    `ICTO_F_P1: st_nxt.ch[sel].p1 =
                        clamp_val(bus_in.wdata); // RULE3
                    `ICTO_F_S1: st_nxt.ch[sel].s1 =
                        clamp_val(bus_in.wdata); // RULE4
                    `ICTO_F_P2: st_nxt.ch[sel].p2 =
                        clamp_val(bus_in.wdata); // RULE3
                    `ICTO_F_S2: st_nxt.ch[sel].s2 =
                        clamp_val(bus_in.wdata); // RULE4
                    `ICTO_F_TC: begin
                        // One divider, paid only on a write
                        if (bus_in.wdata > 32'(`ICTO_TC_MAX)) begin
                            st_nxt.ch[sel].tc = `ICTO_TC_MAX; // RULE5
                        end else begin
                            st_nxt.ch[sel].tc = bus_in.wdata[15:0];
                        end
                        den = 20'(st_nxt.ch[sel].tc * `ICTO_MS_PER_TC);
                        if (den != 20'h0) begin
                            st_nxt.ch[sel].recip =
                                18'(`ICTO_ONE / 45'(den)); // RULE6
                        end
                    end
                    default: ;
                endcase
            end else if (bus_in.addr[7:5] == `ICTO_OUT_SEL) begin
                sel = bus_in.addr[4:3];
                if (run_in) begin
                    ev[`ICTO_IRQ_REFUSED] = 1'b1; // RULE12 RULE16
                end else if (bus_in.addr[2] == `ICTO_F_CODE) begin
                    st_nxt.op[sel].code =
                        (bus_in.wdata[7:0] > `ICTO_CODE_MAX ||
                         bus_in.wdata[31:8] != 24'h0)
                        ? `ICTO_CODE_MAX : bus_in.wdata[7:0]; // RULE7
                end else begin
                    st_nxt.op[sel].per =
                        (bus_in.wdata[6:0] > `ICTO_PER_MAX ||
                         bus_in.wdata[31:7] != 25'h0)
                        ? `ICTO_PER_MAX : bus_in.wdata[6:0]; // RULE14
                end
            end
        end

        // Register reads, answered next cycle
        if (bus_in.rd) begin
            if (bus_in.addr == `ICTO_A_CTRL) begin
                st_nxt.rdata = 32'(st_r.lin);
            end else if (bus_in.addr == `ICTO_A_IRQ_ST) begin
                st_nxt.rdata = 32'(st_r.irq_st);
            end else if (bus_in.addr == `ICTO_A_IRQ_MASK) begin
                st_nxt.rdata = 32'(st_r.irq_mask);
            end else if (bus_in.addr == `ICTO_A_STATE) begin
                st_nxt.rdata = {27'h0, st_r.on, run_in};
            end else if (bus_in.addr[7] == `ICTO_CH_SEL) begin
                sel = bus_in.addr[6:5];
                case (bus_in.addr[4:2])
                    `ICTO_F_P1: st_nxt.rdata = 32'(st_r.ch[sel].p1);
                    `ICTO_F_S1: st_nxt.rdata = 32'(st_r.ch[sel].s1);
                    `ICTO_F_P2: st_nxt.rdata = 32'(st_r.ch[sel].p2);
                    `ICTO_F_S2: st_nxt.rdata = 32'(st_r.ch[sel].s2);
                    `ICTO_F_TC: st_nxt.rdata = 32'(st_r.ch[sel].tc);
                    `ICTO_F_PV: st_nxt.rdata =
                        32'($signed(st_r.ch[sel].flt[39:24]));
                    default: st_nxt.rdata = 32'h0;
                endcase
            end else if (bus_in.addr[7:5] == `ICTO_OUT_SEL) begin
                sel = bus_in.addr[4:3];
                st_nxt.rdata = (bus_in.addr[2] == `ICTO_F_CODE)
                    ? 32'(st_r.op[sel].code) : 32'(st_r.op[sel].per);
            end
        end

        // Filter walks the channels one per cycle after each tick
        case (st_r.ph)
            PH_IDLE: begin
                if (tick) begin
                    st_nxt.ph  = PH_RUN;
                    st_nxt.chi = 2'h0;
                end
            end
            PH_RUN: begin
                xc = correct(meas_in[st_r.chi], st_r.ch[st_r.chi],
                             dp_in[st_r.chi]);
                if (st_r.ch[st_r.chi].tc == 16'h0) begin
                    st_nxt.ch[st_r.chi].flt = {xc, 24'h0}; // RULE6
                end else begin
                    err = 17'(xc) - 17'(st_r.ch[st_r.chi].flt[39:24]);
                    dlt = 37'(err) * 37'($signed({1'b0,
                          st_r.ch[st_r.chi].recip}));
                    st_nxt.ch[st_r.chi].flt = st_r.ch[st_r.chi].flt +
                                              40'(dlt); // RULE5 RULE6
                end
                st_nxt.chi = st_r.chi + 2'h1;
                if (st_r.chi == 2'h3) begin
                    st_nxt.ph = PH_IDLE;
                end
            end
            default: st_nxt.ph = PH_IDLE;
        endcase

        // Output sources and time-proportional drive
        for (int o = 0; o < 4; o++) begin
            src  = 2'((st_r.op[o].code >> 5) - 8'h1);
            prop = st_r.op[o].code >= `ICTO_CODE_GRP &&
                   st_r.op[o].code[4:0] == `ICTO_SUB_PROP; // RULE7
            mv   = mv_in[src];
            if (st_r.op[o].code == `ICTO_CODE_ERR) begin
                dig = |dev_status_in[`ICTO_ERR_MSB:0]; // RULE10
            end else if (st_r.op[o].code >= `ICTO_CODE_GRP) begin
                dig = alarm_in[src];
            end else begin
                dig = 1'b0;
            end
            pms = period_ms(st_r.op[o].per);
            if (tick) begin
                if (st_r.op[o].cnt >= pms - 17'h1) begin
                    st_nxt.op[o].cnt = 17'h0;
                    st_nxt.op[o].mvl = mv; // Level held for a whole period
                    ev[o] = 1'b1;
                end else begin
                    st_nxt.op[o].cnt = st_r.op[o].cnt + 17'h1;
                end
            end
            if (prop && pid_in[src]) begin
                on = 27'(st_r.op[o].cnt) * 27'(`ICTO_PCT_FULL) <
                     27'(st_r.op[o].mvl) * 27'(pms); // RULE13 RULE17
            end else if (prop) begin
                on = mv != 10'h0;
            end else begin
                on = dig;
            end
            if (st_r.lin && o < 2) begin
                // Linear outputs carry no pulse train
                st_nxt.on[o] = 1'b0; // RULE17
                if (prop && pid_in[src]) begin
                    st_nxt.lvl[o] = mv;
                end else begin
                    st_nxt.lvl[o] = on ? `ICTO_PCT_FULL : 10'h0; // RULE11
                end
            end else begin
                st_nxt.on[o]  = on;
                st_nxt.lvl[o] = 10'h0;
            end
        end

        // Events after the clear so a new one is not lost
        st_nxt.irq_st = st_nxt.irq_st | ev;
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            st_r <= '0;
            for (int c = 0; c < 4; c++) begin
                st_r.ch[c].p1 <= `ICTO_P1_RST; // RULE3
                st_r.ch[c].p2 <= `ICTO_P2_RST; // RULE3
                st_r.ch[c].s1 <= `ICTO_S_RST;  // RULE4
                st_r.ch[c].s2 <= `ICTO_S_RST;  // RULE4
                st_r.ch[c].tc <= `ICTO_TC_RST; // RULE5
                st_r.op[c].per <= `ICTO_PER_RST; // RULE14
            end
            st_r.op[0].code <= `ICTO_CODE_O1; // RULE8
            st_r.op[1].code <= `ICTO_CODE_O2; // RULE8
            // Strap is sampled only on this clocked reset
            st_r.op[2].code <= four_ch_in ? `ICTO_CODE_O3_4CH
                                          : `ICTO_CODE_O3_2CH; // RULE8 RULE9
            st_r.op[3].code <= four_ch_in ? `ICTO_CODE_O4_4CH
                                          : `ICTO_CODE_O4_2CH; // RULE8 RULE9
            st_r.ph <= PH_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign rdata_out   = st_r.rdata;
    assign irq_out     = |(st_r.irq_st & st_r.irq_mask);
    assign out_on_out  = st_r.on;
    assign out_lin_out = st_r.lvl;

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            pv_out[c] = st_r.ch[c].flt[39:24];
        end
    end

endmodule

`default_nettype wire

// File: icto_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "icto_defines.svh"

module icto_checker
    import icto_pkg::*;
#(
    parameter int unsigned TICK_CYC = 10
) (
    input wire logic            mclk_in,     // Clock
    input wire logic            rst_b_in,    // Reset, low
    input wire icto_bus_t       bus_in,      // Register port
    input wire logic [31:0]     rdata_out,   // Read data
    input wire logic            irq_out,     // Interrupt
    input wire logic            run_in,      // Running
    input wire logic [3:0]      out_on_out,  // Pulse outputs
    input wire icto_pct_t [3:0] out_lin_out, // Linear levels
    input wire icto_val_t [3:0] pv_out       // Filtered values
);
    logic [4:0] mask_r;
    logic       lin_r;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    // ==========================================================
    // Shadow of mask and mode, so checks need no internal probes
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            mask_r <= 5'h00;
            lin_r  <= 1'b0;
        end else if (bus_in.wr && bus_in.addr == `ICTO_A_IRQ_MASK) begin
            mask_r <= bus_in.wdata[4:0];
        end else if (bus_in.wr && bus_in.addr == `ICTO_A_CTRL) begin
            lin_r <= bus_in.wdata[0];
        end
    end

    // ==========================================================
    // Properties
    sequence s_refused;
        bus_in.wr && bus_in.addr[7:5] == `ICTO_OUT_SEL && run_in;
    endsequence
    sequence s_lone_rd;
        bus_in.rd ##1 !bus_in.rd;
    endsequence

    property p_refuse_irq;
        s_refused ##0 mask_r[4] |=> irq_out;
    endproperty
    a_refuse_irq: assert property (p_refuse_irq)
        else $error("refused write raised no interrupt");
    property p_no_mask;
        mask_r == 5'h00 |-> !irq_out;
    endproperty
    a_no_mask: assert property (p_no_mask)
        else $error("interrupt high with all sources masked");
    property p_lin_pulse;
        lin_r && $past(lin_r) |-> out_on_out[1:0] == 2'b00;
    endproperty
    a_lin_pulse: assert property (p_lin_pulse)
        else $error("pulse output active on linear output");
    property p_lin_idle;
        !lin_r && !$past(lin_r) |->
            out_lin_out[0] == 10'h000 && out_lin_out[1] == 10'h000;
    endproperty
    a_lin_idle: assert property (p_lin_idle)
        else $error("linear level without linear mode");
    property p_lin_full;
        out_lin_out[0] <= `ICTO_PCT_FULL && out_lin_out[1] <= `ICTO_PCT_FULL;
    endproperty
    a_lin_full: assert property (p_lin_full)
        else $error("linear level above full scale");
    property p_lin_34;
        out_lin_out[2] == 10'h000 && out_lin_out[3] == 10'h000;
    endproperty
    a_lin_34: assert property (p_lin_34)
        else $error("linear level on outputs 3 or 4");
    property p_rd_once;
        s_lone_rd |=> rdata_out == 32'h0;
    endproperty
    a_rd_once: assert property (p_rd_once)
        else $error("read data held past one cycle");
    property p_state;
        bus_in.rd && bus_in.addr == `ICTO_A_STATE |=>
            rdata_out[4:0] == {$past(out_on_out), $past(run_in)};
    endproperty
    a_state: assert property (p_state)
        else $error("state word differs from outputs");
    property p_rst_clear;
        $rose(rst_b_in) |-> out_on_out == 4'h0 && pv_out == '0 && !irq_out;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("outputs not cleared by reset");
endmodule

bind icto_core icto_checker #(.TICK_CYC(TICK_CYC)) chk_u (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .run_in(run_in),
    .out_on_out(out_on_out), .out_lin_out(out_lin_out), .pv_out(pv_out)
);

`default_nettype wire

// File: icto_relay.sv
`timescale 1ns/1ps
`default_nettype none

module icto_relay (
    input  wire logic       mclk_in,    // Clock
    input  wire logic       rst_b_in,   // Reset, low
    input  wire logic [3:0] on_in,      // Coil drive
    output logic [3:0][15:0] on_cnt_out // Energised cycles
);
    // ==========================================================
    // Short bench periods keep run time down but wear real relays
    always_ff @(posedge mclk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_b_in) begin
                on_cnt_out[i] <= 16'h0000;
            end else if (on_in[i]) begin
                on_cnt_out[i] <= on_cnt_out[i] + 16'h0001;
            end
        end
    end
endmodule

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import icto_pkg::*;
;
    localparam int TICK = 10;
    localparam int ON_EXP = 250 * 500 * TICK / 1000;
    logic            mclk_in  = 1'b0;
    logic            rst_b_in = 1'b0;
    logic            four_ch  = 1'b0;
    logic            run      = 1'b0;
    icto_bus_t       bus      = '0;
    icto_val_t [3:0] meas     = '0;
    logic [3:0][1:0] dp       = {4{2'b01}};
    icto_pct_t [3:0] mv       = '0;
    logic [3:0]      pid      = 4'h0;
    logic [3:0]      alarm    = 4'h0;
    logic [15:0]     stat     = 16'h0000;
    logic [31:0]     rdata;
    logic            irq;
    logic [3:0]      on;
    icto_pct_t [3:0] lin;
    icto_val_t [3:0] pv;
    logic [3:0][15:0] cnt;
    int err_total   = 0;
    int check_count = 0;
    int cyc         = 0;
    int tp1[4] = '{0, 40, 100, 0};
    int ts1[4] = '{12, -15, 5, 25};
    int tp2[4] = '{1000, 500, 100, 1000};
    int ts2[4] = '{12, 50, 30, 25};
    int tpv[4] = '{212, 1075, 305, 102};

    always #2 mclk_in = ~mclk_in;

    icto_core #(.TICK_CYC(TICK)) dut_u (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .four_ch_in(four_ch),
        .bus_in(bus), .rdata_out(rdata), .irq_out(irq), .run_in(run),
        .meas_in(meas), .dp_in(dp), .mv_in(mv), .pid_in(pid),
        .alarm_in(alarm), .dev_status_in(stat), .out_on_out(on),
        .out_lin_out(lin), .pv_out(pv)
    );
    icto_relay relay_u (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .on_in(on),
        .on_cnt_out(cnt)
    );

    // ==========================================================
    // Bus and compare tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus <= '0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in);
        bus <= '0;
        #1 chk(rdata, exp);
    endtask
    task automatic rc_rng(input logic [7:0] a, input int lo, input int hi);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in);
        bus <= '0;
        #1 chk(32'($signed(rdata) >= lo && $signed(rdata) <= hi), 32'h1);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(posedge mclk_in);
            #1 n++;
        end while (irq !== 1'b1 && n < 6000);
        chk({31'h0, irq}, 32'h1);
    endtask
    task automatic do_reset(input logic v);
        @(posedge mclk_in);
        rst_b_in <= 1'b0;
        four_ch  <= v;
        repeat (3) @(posedge mclk_in);
        rst_b_in <= 1'b1;
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end

    // ==========================================================
    // Tests
    initial begin
        logic [15:0] a0, a2;
        do_reset(1'b0);
        rc(8'h50, 32'd32);
        rc(8'h58, 32'd64);
        $display("Test two-channel defaults done");
        do_reset(1'b1);
        for (int o = 0; o < 4; o++) begin
            rc(8'(8'h40 + 8 * o), 32'(47 + 32 * o));
            rc(8'(8'h44 + 8 * o), 32'd2);
            rc(8'(8'h80 + 32 * o), 32'd0);
            rc(8'(8'h88 + 32 * o), 32'd1000);
            rc(8'(8'h8c + 32 * o), 32'd0);
            rc(8'(8'h90 + 32 * o), 32'd0);
        end
        wr(8'h80, 32'd20000);
        rc(8'h80, 32'h270f);
        wr(8'h84, 32'hffffec78);
        rc(8'h84, 32'hfffff831);
        wr(8'h90, 32'd20000);
        rc(8'h90, 32'h270f);
        wr(8'h44, 32'd200);
        rc(8'h44, 32'd99);
        wr(8'h40, 32'd200);
        rc(8'h40, 32'd144);
        rc(8'hfc, 32'h0);
        $display("Test defaults and limits done");
        wr(8'h08, 32'h10);
        run <= 1'b1;
        wr(8'h48, 32'd1);
        wr(8'h4c, 32'd5);
        rc(8'h48, 32'd79);
        rc(8'h4c, 32'd2);
        rc(8'h0c, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rc(8'h04, 32'h10);
        wr(8'h04, 32'h10);
        run <= 1'b0;
        rc(8'h04, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("Test refused writes done");
        wr(8'h40, 32'd47);
        wr(8'h44, 32'd0);
        wr(8'h50, 32'd47);
        wr(8'h54, 32'd0);
        wr(8'h48, 32'd1);
        wr(8'h58, 32'd32);
        wr(8'h90, 32'd0);
        for (int c = 0; c < 4; c++) begin
            wr(8'(8'h80 + 32 * c), 32'(tp1[c]));
            wr(8'(8'h84 + 32 * c), 32'(ts1[c]));
            wr(8'(8'h88 + 32 * c), 32'(tp2[c]));
            wr(8'(8'h8c + 32 * c), 32'(ts2[c]));
        end
        dp   <= {2'b00, 2'b01, 2'b01, 2'b01};
        meas <= {16'sd100, 16'sd300, 16'sd960, 16'sd200};
        pid  <= 4'h1;
        mv   <= {10'd0, 10'd0, 10'd0, 10'd250};
        stat <= 16'h2000;
        repeat (40) @(posedge mclk_in);
        for (int c = 0; c < 4; c++) begin
            rc(8'(8'h94 + 32 * c), 32'(tpv[c]));
            chk(32'(pv[c]), 32'(tpv[c]));
        end
        chk({31'h0, on[1]}, 32'h1);
        @(posedge mclk_in);
        stat  <= 16'h4000;
        alarm <= 4'h1;
        repeat (3) @(posedge mclk_in);
        #1 chk({31'h0, on[1]}, 32'h0);
        chk({31'h0, on[3]}, 32'h1);
        $display("Test correction and sources done");
        wr(8'h90, 32'd1);
        meas[0] <= 16'sd1200;
        repeat (100 * TICK) @(posedge mclk_in);
        rc_rng(8'h94, 800, 870);
        repeat (1000 * TICK) @(posedge mclk_in);
        rc_rng(8'h94, 1205, 1212);
        $display("Test filter done");
        wr(8'h08, 32'h1);
        wait_irq();
        wr(8'h04, 32'h1);
        wait_irq();
        a0 = cnt[0];
        a2 = cnt[2];
        wr(8'h04, 32'h1);
        wait_irq();
        chk(32'(cnt[0] - a0), 32'(ON_EXP));
        chk(32'(cnt[2] - a2), 32'(ON_EXP));
        $display("Test time-proportional output done");
        wr(8'h00, 32'h1);
        repeat (3) @(posedge mclk_in);
        #1 chk(32'(lin[0]), 32'd250);
        chk(32'(on[1:0]), 32'h0);
        @(posedge mclk_in);
        stat <= 16'h0001;
        pid  <= 4'h0;
        repeat (3) @(posedge mclk_in);
        #1 chk(32'(lin[1]), 32'd1000);
        chk(32'(lin[0]), 32'd1000);
        $display("Test linear outputs done");
        end_sim();
    end
endmodule

`default_nettype wire
